// [bhwc_pkg.sv]
// Constants for the bridge header window and control register block
package bhwc_pkg;

    // Configuration dword offsets
    localparam logic [7:0]  OFF_PF_BASE_UP = 8'h28;
    localparam logic [7:0]  OFF_PF_LIM_UP  = 8'h2C;
    localparam logic [7:0]  OFF_IO_UP      = 8'h30;
    localparam logic [7:0]  OFF_CAP_PTR    = 8'h34;
    localparam logic [7:0]  OFF_INT_BC     = 8'h3C;

    // Reset values
    localparam logic [31:0] PF_UP_RST      = 32'h0000_0000;
    localparam logic [15:0] IO_UP_RST      = 16'h0000;
    localparam logic [7:0]  CAP_PTR_RST    = 8'h40;
    localparam logic [7:0]  INT_LINE_RST   = 8'h00;
    localparam logic [7:0]  INT_PIN_RST    = 8'h00;
    localparam logic        BC_BIT_RST     = 1'b0;

    // Field positions inside the dwords
    localparam int          IO_LIM_LSB     = 16;
    localparam int          INT_PIN_LSB    = 8;
    localparam int          BC_BYTE        = 2;
    localparam int          BC_PERR        = 16;
    localparam int          BC_SERR        = 17;
    localparam int          BC_ISA         = 18;
    localparam int          BC_VGA         = 19;
    localparam int          BC_VGA16       = 20;
    localparam int          BC_SBR         = 22;

    // Implied low address bits of the forwarding windows
    localparam logic [19:0] PF_BASE_LOW    = 20'h00000;
    localparam logic [19:0] PF_LIM_LOW     = 20'hFFFFF;
    localparam logic [11:0] IO_BASE_LOW    = 12'h000;
    localparam logic [11:0] IO_LIM_LOW     = 12'hFFF;

    // Legacy decode ranges
    localparam logic [31:0] VGA_MEM_LO     = 32'h000A_0000;
    localparam logic [31:0] VGA_MEM_HI     = 32'h000B_FFFF;
    localparam logic [9:0]  VGA_IO_A_LO    = 10'h3B0;
    localparam logic [9:0]  VGA_IO_A_HI    = 10'h3BB;
    localparam logic [9:0]  VGA_IO_B_LO    = 10'h3C0;
    localparam logic [9:0]  VGA_IO_B_HI    = 10'h3DF;
    localparam logic [9:0]  ISA_BLK_LO_END = 10'h0FF;

    // Number of downstream ports of the switch
    localparam int          NUM_DS         = 3;

endpackage

// [bhwc_range_cmp.sv]
// Inclusive range compare of an address against a bottom and a top
`timescale 1ns/1ns
`default_nettype none
module bhwc_range_cmp
#(
    parameter int W = 32
)
(
    // Address and window bounds
    input  wire logic [W-1:0] addr,
    input  wire logic [W-1:0] lo,
    input  wire logic [W-1:0] hi,
    // Result
    output logic              hit
);

    assign hit = (addr >= lo) && (addr <= hi); // R18

endmodule
`default_nettype wire

// [bhwc_legacy_dec.sv]
// Legacy ISA and video address decode
`timescale 1ns/1ns
`default_nettype none
module bhwc_legacy_dec
    import bhwc_pkg::*;
(
    // Addresses under decode
    input  wire logic [31:0] io_addr,
    input  wire logic [63:0] mem_addr,
    // Video decode width select
    input  wire logic        vga16,
    // Results
    output logic             vga_mem_hit,
    output logic             vga_io_hit,
    output logic             isa_top_hit
);

    logic       first_64k;
    logic [9:0] low10;
    logic       upper_ok;
    logic       in_ranges;

    assign first_64k = (io_addr[31:16] == 16'h0000);
    assign low10     = io_addr[9:0];
    // Upper six bits only matter with the wide decode
    assign upper_ok  = vga16 ? (io_addr[15:10] == 6'h00) : 1'b1; // R14
    assign in_ranges = ((low10 >= VGA_IO_A_LO) && (low10 <= VGA_IO_A_HI))
                    || ((low10 >= VGA_IO_B_LO) && (low10 <= VGA_IO_B_HI));

    assign vga_io_hit  = first_64k && upper_ok && in_ranges; // R13
    assign vga_mem_hit = (mem_addr[63:32] == 32'h0000_0000)
                      && (mem_addr[31:0] >= VGA_MEM_LO)
                      && (mem_addr[31:0] <= VGA_MEM_HI); // R12
    assign isa_top_hit = first_64k && (low10 > ISA_BLK_LO_END); // R11

endmodule
`default_nettype wire

// [bhwc_top.sv]
// Upper bridge header registers, window decode and bridge control
// How it works
// R1 - Writable upper 32 bits of prefetch top
// R2 - Writable upper 32 bits of prefetch bottom
// R3 - Prefetch top low twenty bits are ones
// R4 - I/O bottom upper 16 bits, low half
// R5 - I/O top upper 16 bits, high half
// R6 - Capability pointer read-only, returns 40h
// R7 - Interrupt pin read-only, reset zero
// R8 - Sideband load replaces downstream interrupt pin
// R9 - Poison response bit gates poison reporting
// R10 - Error forward bit gates error messages
// R11 - ISA bit sends block-top I/O upstream
// R12 - VGA bit forwards legacy video memory
// R13 - VGA bit forwards legacy video I/O
// R14 - Decode width bit picks 10/16 bits
// R15 - Downstream reset bit drives own port reset
// R16 - Upstream reset bit resets every downstream
// R17 - Legacy PCI control bits read zero
// R18 - Window hit is inclusive full-width compare
// R19 - Reserved control bits read zero
`timescale 1ns/1ns
`default_nettype none
module bhwc_top
    import bhwc_pkg::*;
(
    // Clock, reset, enable
    input  wire logic              sys_clk,
    input  wire logic              nrst,
    input  wire logic              ce,
    // Configuration requests
    input  wire logic              cfg_wr,
    input  wire logic              cfg_rd,
    input  wire logic [7:0]        cfg_addr,
    input  wire logic [3:0]        cfg_be,
    input  wire logic [31:0]       cfg_wdata,
    output logic      [31:0]       cfg_rdata,
    output logic                   cfg_rvalid,
    // Port role
    input  wire logic              is_upstream,
    input  wire logic [NUM_DS-1:0] ds_port_sel,
    // Sideband interrupt pin load
    input  wire logic              pin_load_we,
    input  wire logic [7:0]        pin_load_val,
    // Lower header window bits
    input  wire logic [11:0]       pf_base_lo,
    input  wire logic [11:0]       pf_lim_lo,
    input  wire logic [3:0]        io_base_lo,
    input  wire logic [3:0]        io_lim_lo,
    // Address decode requests
    input  wire logic              mem_valid,
    input  wire logic [63:0]       mem_addr,
    input  wire logic              io_valid,
    input  wire logic [31:0]       io_addr,
    // Address decode results
    output logic                   pf_hit,
    output logic                   vga_mem_fwd,
    output logic                   io_fwd_down,
    output logic                   io_fwd_up,
    output logic                   vga_io_fwd,
    // Secondary side events
    input  wire logic              sec_poison,
    input  wire logic              sec_err_valid,
    input  wire logic [1:0]        sec_err_type,
    output logic                   poison_report,
    output logic                   pri_err_valid,
    output logic      [1:0]        pri_err_type,
    // Downstream port resets
    output logic      [NUM_DS-1:0] port_rst_n
);

    typedef struct packed {
        logic [31:0]       pf_base_up;
        logic [31:0]       pf_lim_up;
        logic [15:0]       io_base_up;
        logic [15:0]       io_lim_up;
        logic [7:0]        int_line;
        logic [7:0]        int_pin;
        logic              perr_resp;
        logic              serr_fwd;
        logic              isa_en;
        logic              vga_en;
        logic              vga16;
        logic              sec_rst;
        logic [31:0]       rdata;
        logic              rvalid;
        logic              pf_hit;
        logic              vga_mem;
        logic              io_down;
        logic              io_up;
        logic              vga_io;
        logic              poison_rep;
        logic              err_valid;
        logic [1:0]        err_type;
        logic [NUM_DS-1:0] rst_n;
    } bhwc_state_t;

    localparam bhwc_state_t ST_RST = '{
        pf_base_up: PF_UP_RST,
        pf_lim_up:  PF_UP_RST,
        io_base_up: IO_UP_RST,
        io_lim_up:  IO_UP_RST,
        int_line:   INT_LINE_RST,
        int_pin:    INT_PIN_RST,
        perr_resp:  BC_BIT_RST,
        serr_fwd:   BC_BIT_RST,
        isa_en:     BC_BIT_RST,
        vga_en:     BC_BIT_RST,
        vga16:      BC_BIT_RST,
        sec_rst:    BC_BIT_RST,
        rst_n:      '1,
        default:    '0
    };

    bhwc_state_t st_r;
    bhwc_state_t st_nxt;

    logic [63:0] pf_lo;
    logic [63:0] pf_hi;
    logic [31:0] io_lo;
    logic [31:0] io_hi;
    logic        pf_in;
    logic        io_in;
    logic        vga_mem_hit;
    logic        vga_io_hit;
    logic        isa_top_hit;
    logic [31:0] rd_word;

    // Byte-lane merge of a write into a dword
    function automatic logic [31:0] be_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Dword at the interrupt and bridge control offset
    function automatic logic [31:0] int_bc_word(input bhwc_state_t s);
        logic [31:0] w;
        w = 32'h0000_0000; // R17 R19
        w[7:0] = s.int_line;
        w[INT_PIN_LSB +: 8] = s.int_pin;
        w[BC_PERR] = s.perr_resp;
        w[BC_SERR] = s.serr_fwd;
        w[BC_ISA] = s.isa_en;
        w[BC_VGA] = s.vga_en;
        w[BC_VGA16] = s.vga16;
        w[BC_SBR] = s.sec_rst;
        return w;
    endfunction

    assign pf_lo = {st_r.pf_base_up, pf_base_lo, PF_BASE_LOW}; // R2
    assign pf_hi = {st_r.pf_lim_up, pf_lim_lo, PF_LIM_LOW}; // R1 R3
    assign io_lo = {st_r.io_base_up, io_base_lo, IO_BASE_LOW}; // R4
    assign io_hi = {st_r.io_lim_up, io_lim_lo, IO_LIM_LOW}; // R5

    bhwc_range_cmp #(.W(64)) u_pf_cmp (
        .addr (mem_addr),
        .lo   (pf_lo),
        .hi   (pf_hi),
        .hit  (pf_in)
    );

    bhwc_range_cmp #(.W(32)) u_io_cmp (
        .addr (io_addr),
        .lo   (io_lo),
        .hi   (io_hi),
        .hit  (io_in)
    );

    bhwc_legacy_dec u_legacy (
        .io_addr     (io_addr),
        .mem_addr    (mem_addr),
        .vga16       (st_r.vga16),
        .vga_mem_hit (vga_mem_hit),
        .vga_io_hit  (vga_io_hit),
        .isa_top_hit (isa_top_hit)
    );

    always_comb
    begin
        case (cfg_addr)
            OFF_PF_BASE_UP: rd_word = st_r.pf_base_up;
            OFF_PF_LIM_UP:  rd_word = st_r.pf_lim_up;
            OFF_IO_UP:      rd_word = {st_r.io_lim_up, st_r.io_base_up};
            OFF_CAP_PTR:    rd_word = {24'h000000, CAP_PTR_RST}; // R6
            OFF_INT_BC:     rd_word = int_bc_word(st_r);
            default:        rd_word = 32'h0000_0000;
        endcase
    end

    always_comb
    begin
        logic [31:0] io_word;
        io_word = be_merge({st_r.io_lim_up, st_r.io_base_up}, cfg_wdata,
                           cfg_be);
        st_nxt = st_r;
        if (cfg_wr)
        begin
            case (cfg_addr)
                OFF_PF_BASE_UP:
                begin
                    st_nxt.pf_base_up = be_merge(st_r.pf_base_up, cfg_wdata,
                                                 cfg_be); // R2
                end
                OFF_PF_LIM_UP:
                begin
                    st_nxt.pf_lim_up = be_merge(st_r.pf_lim_up, cfg_wdata,
                                                cfg_be); // R1
                end
                OFF_IO_UP:
                begin
                    st_nxt.io_base_up = io_word[15:0]; // R4
                    st_nxt.io_lim_up = io_word[IO_LIM_LSB +: 16]; // R5
                end
                OFF_INT_BC:
                begin
                    if (cfg_be[0])
                    begin
                        st_nxt.int_line = cfg_wdata[7:0];
                    end
                    // Upper byte holds only fixed and reserved bits
                    if (cfg_be[BC_BYTE])
                    begin
                        st_nxt.perr_resp = cfg_wdata[BC_PERR]; // R9
                        st_nxt.serr_fwd = cfg_wdata[BC_SERR]; // R10
                        st_nxt.isa_en = cfg_wdata[BC_ISA]; // R11
                        st_nxt.vga_en = cfg_wdata[BC_VGA]; // R12
                        st_nxt.vga16 = cfg_wdata[BC_VGA16]; // R14
                        st_nxt.sec_rst = cfg_wdata[BC_SBR]; // R15
                    end
                end
                default:
                begin
                end
            endcase
        end
        // Interrupt pin is loaded by sideband only, never by config
        if (pin_load_we && !is_upstream)
        begin
            st_nxt.int_pin = pin_load_val; // R7 R8
        end
        st_nxt.rvalid = cfg_rd;
        if (cfg_rd)
        begin
            st_nxt.rdata = rd_word;
        end
        st_nxt.pf_hit = mem_valid && pf_in; // R18
        st_nxt.vga_mem = mem_valid && st_r.vga_en && vga_mem_hit; // R12
        st_nxt.io_down = io_valid && io_in
                      && !(st_r.isa_en && isa_top_hit); // R11
        st_nxt.io_up = io_valid && io_in && st_r.isa_en && isa_top_hit;
        st_nxt.vga_io = io_valid && st_r.vga_en && vga_io_hit; // R13
        st_nxt.poison_rep = sec_poison && st_r.perr_resp; // R9
        st_nxt.err_valid = sec_err_valid && st_r.serr_fwd; // R10
        if (sec_err_valid)
        begin
            st_nxt.err_type = sec_err_type;
        end
        for (int i = 0; i < NUM_DS; i++)
        begin
            st_nxt.rst_n[i] = !(st_r.sec_rst
                             && (is_upstream || ds_port_sel[i])); // R15 R16
        end
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_r <= ST_RST;
        end
        else if (ce)
        begin
            st_r <= st_nxt;
        end
    end

    assign cfg_rdata     = st_r.rdata;
    assign cfg_rvalid    = st_r.rvalid;
    assign pf_hit        = st_r.pf_hit;
    assign vga_mem_fwd   = st_r.vga_mem;
    assign io_fwd_down   = st_r.io_down;
    assign io_fwd_up     = st_r.io_up;
    assign vga_io_fwd    = st_r.vga_io;
    assign poison_report = st_r.poison_rep;
    assign pri_err_valid = st_r.err_valid;
    assign pri_err_type  = st_r.err_type;
    assign port_rst_n    = st_r.rst_n;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    sequence s_wr_lim;
        ce && cfg_wr && cfg_addr == OFF_PF_LIM_UP && cfg_be == 4'hF;
    endsequence

    sequence s_set_sbr;
        ce && cfg_wr && cfg_addr == OFF_INT_BC && cfg_be[BC_BYTE]
            && cfg_wdata[BC_SBR];
    endsequence

    sequence s_rd_ctrl;
        ce && cfg_rd && cfg_addr == OFF_INT_BC;
    endsequence

    a_pf_limit_write: assert property ( // R1
        s_wr_lim |=> pf_hi[63:32] == $past(cfg_wdata))
        else $error("prefetch top upper bits not written");

    a_cap_ptr_read: assert property ( // R6
        ce && cfg_rd && cfg_addr == OFF_CAP_PTR
        |=> cfg_rvalid && cfg_rdata == {24'h000000, CAP_PTR_RST})
        else $error("capability pointer read wrong");

    a_ctrl_fixed_zero: assert property ( // R17
        s_rd_ctrl |=> cfg_rvalid && cfg_rdata[BC_SBR - 1] == 1'b0
                      && cfg_rdata[31:BC_SBR + 1] == 9'h000)
        else $error("fixed control bits not zero");

    a_poison_gated: assert property ( // R9
        ce && sec_poison && !st_r.perr_resp |=> !poison_report)
        else $error("poison reported while response off");

    a_err_forward: assert property ( // R10
        ce && sec_err_valid && st_r.serr_fwd
        |=> pri_err_valid && pri_err_type == $past(sec_err_type))
        else $error("error message not forwarded");

    a_up_reset_all: assert property ( // R16
        (s_set_sbr and is_upstream) ##1 (ce && is_upstream)
        |=> port_rst_n == '0)
        else $error("upstream reset missed a downstream port");

    a_vga_mem_gate: assert property ( // R12
        ce && mem_valid && !st_r.vga_en |=> !vga_mem_fwd)
        else $error("video memory forwarded while disabled");

    a_io_window_low: assert property ( // R18
        ce && io_valid && io_addr < io_lo |=> !io_fwd_down && !io_fwd_up)
        else $error("I/O below window forwarded");

    a_isa_split: assert property ( // R11
        ce && io_valid && io_in && st_r.isa_en && isa_top_hit
        |=> io_fwd_up && !io_fwd_down)
        else $error("ISA top address not sent upstream");

    a_pin_cfg_ro: assert property ( // R7
        ce && cfg_wr && cfg_addr == OFF_INT_BC && !pin_load_we
        |=> $stable(st_r.int_pin))
        else $error("interrupt pin changed by config write");

endmodule
`default_nettype wire

// [bhwc_rc_model.sv]
// Root complex model that issues configuration requests to the block
`timescale 1ns/1ns
`default_nettype none
module bhwc_rc_model
(
    // Clock
    input  wire logic        sys_clk,
    // Configuration requests and answers
    output var  logic        cfg_wr,
    output var  logic        cfg_rd,
    output var  logic [7:0]  cfg_addr,
    output var  logic [3:0]  cfg_be,
    output var  logic [31:0] cfg_wdata,
    input  wire logic [31:0] cfg_rdata,
    input  wire logic        cfg_rvalid
);
    initial
    begin
        cfg_wr = 1'b0;
        cfg_rd = 1'b0;
        cfg_addr = 8'h00;
        cfg_be = 4'h0;
        cfg_wdata = 32'h0;
    end

    // Released lines carry the inverse so a stale value cannot pass
    task automatic cfg_write(input logic [7:0] a, input logic [3:0] be,
                             input logic [31:0] d);
        @(posedge sys_clk);
        cfg_wr <= 1'b1;
        cfg_addr <= a;
        cfg_be <= be;
        cfg_wdata <= d;
        @(posedge sys_clk);
        cfg_wr <= 1'b0;
        cfg_addr <= ~a;
        cfg_be <= ~be;
        cfg_wdata <= ~d;
    endtask

    // Answer is looked at in the cycle after the taking edge
    task automatic cfg_read(input logic [7:0] a, output logic [31:0] d,
                            output logic ok);
        @(posedge sys_clk);
        cfg_rd <= 1'b1;
        cfg_addr <= a;
        @(posedge sys_clk);
        cfg_rd <= 1'b0;
        cfg_addr <= ~a;
        #1;
        ok = cfg_rvalid;
        d = cfg_rdata;
    endtask
endmodule
`default_nettype wire

// [test_bridge_header_window_and_control.sv]
// Self-checking bench of the bridge header window and control block
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp, msg) \
    begin \
        check_count++; \
        if ((got) !== (exp)) \
        begin \
            failures++; \
            $display("mismatch t=%0t %s", $time, msg); \
        end \
    end
module test_bridge_header_window_and_control
    import bhwc_pkg::*;
();
    logic              sys_clk, nrst, ce, cfg_wr, cfg_rd, cfg_rvalid;
    logic              is_upstream, pin_load_we, mem_valid, io_valid;
    logic              pf_hit, vga_mem_fwd, io_fwd_down, io_fwd_up;
    logic              vga_io_fwd, sec_poison, sec_err_valid;
    logic              poison_report, pri_err_valid;
    logic [1:0]        sec_err_type, pri_err_type;
    logic [3:0]        cfg_be, io_base_lo, io_lim_lo;
    logic [7:0]        cfg_addr, pin_load_val;
    logic [11:0]       pf_base_lo, pf_lim_lo;
    logic [31:0]       cfg_wdata, cfg_rdata, io_addr;
    logic [63:0]       mem_addr;
    logic [NUM_DS-1:0] ds_port_sel, port_rst_n;
    int                failures, check_count;

    bhwc_top bhwc_top_inst
    (
        .sys_clk(sys_clk), .nrst(nrst), .ce(ce),
        .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
        .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .cfg_rvalid(cfg_rvalid), .is_upstream(is_upstream),
        .ds_port_sel(ds_port_sel), .pin_load_we(pin_load_we),
        .pin_load_val(pin_load_val), .pf_base_lo(pf_base_lo),
        .pf_lim_lo(pf_lim_lo), .io_base_lo(io_base_lo),
        .io_lim_lo(io_lim_lo), .mem_valid(mem_valid), .mem_addr(mem_addr),
        .io_valid(io_valid), .io_addr(io_addr), .pf_hit(pf_hit),
        .vga_mem_fwd(vga_mem_fwd), .io_fwd_down(io_fwd_down),
        .io_fwd_up(io_fwd_up), .vga_io_fwd(vga_io_fwd),
        .sec_poison(sec_poison), .sec_err_valid(sec_err_valid),
        .sec_err_type(sec_err_type), .poison_report(poison_report),
        .pri_err_valid(pri_err_valid), .pri_err_type(pri_err_type),
        .port_rst_n(port_rst_n)
    );

    bhwc_rc_model bhwc_rc_model_inst
    (
        .sys_clk(sys_clk), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
        .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid)
    );

    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Tests need some 170 cycles; the limit allows 2000
    initial
    begin
        #8000;
        failures++;
        $display("mismatch t=%0t watchdog expired", $time);
        final_report();
    end

    task automatic wr(input logic [7:0] a, input logic [3:0] be,
                      input logic [31:0] d);
        bhwc_rc_model_inst.cfg_write(a, be, d);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic        ok;
        bhwc_rc_model_inst.cfg_read(a, d, ok);
        `CHK(ok, 1'b1, "no read answer")
        `CHK(d, e, "read data")
    endtask

    task automatic mem_dec(input logic [63:0] a, input logic e_pf, e_vga);
        @(posedge sys_clk);
        mem_valid <= 1'b1;
        mem_addr <= a;
        @(posedge sys_clk);
        mem_valid <= 1'b0;
        mem_addr <= ~a;
        #1;
        `CHK(pf_hit, e_pf, "prefetch hit")
        `CHK(vga_mem_fwd, e_vga, "video memory forward")
    endtask

    task automatic io_dec(input logic [31:0] a, input logic e_dn, e_up,
                          e_vga);
        @(posedge sys_clk);
        io_valid <= 1'b1;
        io_addr <= a;
        @(posedge sys_clk);
        io_valid <= 1'b0;
        io_addr <= ~a;
        #1;
        `CHK(io_fwd_down, e_dn, "io forward down")
        `CHK(io_fwd_up, e_up, "io forward up")
        `CHK(vga_io_fwd, e_vga, "video io forward")
    endtask

    task automatic ev_chk(input logic [1:0] ty, input logic e_p, e_e);
        @(posedge sys_clk);
        sec_poison <= 1'b1;
        sec_err_valid <= 1'b1;
        sec_err_type <= ty;
        @(posedge sys_clk);
        sec_poison <= 1'b0;
        sec_err_valid <= 1'b0;
        sec_err_type <= ~ty;
        #1;
        `CHK(poison_report, e_p, "poison report")
        `CHK(pri_err_valid, e_e, "error forward")
        if (e_e)
            `CHK(pri_err_type, ty, "error type")
    endtask

    task automatic pin_pulse(input logic [7:0] v, input logic up);
        @(posedge sys_clk);
        is_upstream <= up;
        pin_load_we <= 1'b1;
        pin_load_val <= v;
        @(posedge sys_clk);
        pin_load_we <= 1'b0;
        pin_load_val <= ~v;
    endtask

    task automatic t_reset_values();
        rd_chk(8'h2C, 32'h0000_0000);
        rd_chk(8'h28, 32'h0000_0000);
        rd_chk(8'h30, 32'h0000_0000);
        rd_chk(8'h34, 32'h0000_0040);
        rd_chk(8'h3C, 32'h0000_0000);
        rd_chk(8'h38, 32'h0000_0000);
        `CHK(port_rst_n, 3'b111, "port reset idle")
        $display("end t_reset_values");
    endtask

    task automatic t_reg_access();
        wr(8'h2C, 4'hF, 32'hA5C3_0F81);
        rd_chk(8'h2C, 32'hA5C3_0F81);
        wr(8'h28, 4'hF, 32'h5A3C_F07E);
        rd_chk(8'h28, 32'h5A3C_F07E);
        wr(8'h30, 4'h3, 32'h1234_5678);
        rd_chk(8'h30, 32'h0000_5678);
        wr(8'h30, 4'hC, 32'h9ABC_0000);
        rd_chk(8'h30, 32'h9ABC_5678);
        wr(8'h34, 4'hF, 32'hFFFF_FFFF);
        rd_chk(8'h34, 32'h0000_0040);
        wr(8'h3C, 4'hF, 32'hFFBF_FFFF);
        rd_chk(8'h3C, 32'h001F_00FF);
        wr(8'h3C, 4'hF, 32'h0000_0000);
        $display("end t_reg_access");
    endtask

    task automatic t_pin_load();
        pin_pulse(8'h01, 1'b0);
        rd_chk(8'h3C, 32'h0000_0100);
        pin_pulse(8'h02, 1'b1);
        rd_chk(8'h3C, 32'h0000_0100);
        pin_pulse(8'h04, 1'b0);
        rd_chk(8'h3C, 32'h0000_0400);
        $display("end t_pin_load");
    endtask

    task automatic t_prefetch();
        wr(8'h28, 4'hF, 32'h0000_0001);
        wr(8'h2C, 4'hF, 32'h0000_0002);
        pf_base_lo <= 12'h100;
        pf_lim_lo <= 12'h100;
        mem_dec(64'h1_1000_0000, 1'b1, 1'b0);
        mem_dec(64'h1_0FFF_FFFF, 1'b0, 1'b0);
        mem_dec(64'h2_100F_FFFF, 1'b1, 1'b0);
        mem_dec(64'h2_1010_0000, 1'b0, 1'b0);
        mem_dec(64'h0_1000_0000, 1'b0, 1'b0);
        mem_dec(64'h3_1000_0000, 1'b0, 1'b0);
        $display("end t_prefetch");
    endtask

    task automatic t_vga();
        wr(8'h30, 4'hF, 32'h0000_0000);
        io_base_lo <= 4'h2;
        io_lim_lo <= 4'h3;
        mem_dec(64'hA_0000, 1'b0, 1'b0);
        io_dec(32'h03C0, 1'b0, 1'b0, 1'b0);
        wr(8'h3C, 4'h4, 32'h0008_0000);
        mem_dec(64'h9_FFFF, 1'b0, 1'b0);
        mem_dec(64'hA_0000, 1'b0, 1'b1);
        mem_dec(64'hB_FFFF, 1'b0, 1'b1);
        mem_dec(64'hC_0000, 1'b0, 1'b0);
        io_dec(32'h03BB, 1'b0, 1'b0, 1'b1);
        io_dec(32'h03BC, 1'b0, 1'b0, 1'b0);
        io_dec(32'h03DF, 1'b0, 1'b0, 1'b1);
        io_dec(32'h03E0, 1'b0, 1'b0, 1'b0);
        io_dec(32'h13B0, 1'b0, 1'b0, 1'b1);
        io_dec(32'h1_03B0, 1'b0, 1'b0, 1'b0);
        wr(8'h3C, 4'h4, 32'h0018_0000);
        io_dec(32'h13B0, 1'b0, 1'b0, 1'b0);
        io_dec(32'h03C0, 1'b0, 1'b0, 1'b1);
        $display("end t_vga");
    endtask

    task automatic t_isa_window();
        wr(8'h3C, 4'h4, 32'h0000_0000);
        io_dec(32'h2000, 1'b1, 1'b0, 1'b0);
        io_dec(32'h3FFF, 1'b1, 1'b0, 1'b0);
        io_dec(32'h1FFF, 1'b0, 1'b0, 1'b0);
        io_dec(32'h4000, 1'b0, 1'b0, 1'b0);
        wr(8'h3C, 4'h4, 32'h0004_0000);
        io_dec(32'h2100, 1'b0, 1'b1, 1'b0);
        io_dec(32'h23FF, 1'b0, 1'b1, 1'b0);
        io_dec(32'h24FF, 1'b1, 1'b0, 1'b0);
        wr(8'h30, 4'hF, 32'h0002_0001);
        io_dec(32'h1_2100, 1'b1, 1'b0, 1'b0);
        io_dec(32'h2_3FFF, 1'b1, 1'b0, 1'b0);
        io_dec(32'h2_4000, 1'b0, 1'b0, 1'b0);
        io_dec(32'h2100, 1'b0, 1'b0, 1'b0);
        $display("end t_isa_window");
    endtask

    task automatic t_events();
        wr(8'h3C, 4'h4, 32'h0000_0000);
        ev_chk(2'b01, 1'b0, 1'b0);
        wr(8'h3C, 4'h4, 32'h0001_0000);
        ev_chk(2'b10, 1'b1, 1'b0);
        wr(8'h3C, 4'h4, 32'h0002_0000);
        ev_chk(2'b11, 1'b0, 1'b1);
        ev_chk(2'b00, 1'b0, 1'b1);
        $display("end t_events");
    endtask

    task automatic t_clock_enable();
        @(posedge sys_clk);
        ce <= 1'b0;
        wr(8'h2C, 4'hF, 32'h0000_00FF);
        ce <= 1'b1;
        rd_chk(8'h2C, 32'h0000_0002);
        $display("end t_clock_enable");
    endtask

    task automatic t_port_reset();
        wr(8'h3C, 4'h4, 32'h0040_0000);
        @(posedge sys_clk);
        #1;
        `CHK(port_rst_n, 3'b101, "own port reset")
        wr(8'h3C, 4'h4, 32'h0000_0000);
        is_upstream <= 1'b1;
        @(posedge sys_clk);
        #1;
        `CHK(port_rst_n, 3'b111, "own port release")
        wr(8'h3C, 4'h4, 32'h0040_0000);
        @(posedge sys_clk);
        #1;
        `CHK(port_rst_n, 3'b000, "all ports reset")
        wr(8'h3C, 4'h4, 32'h0000_0000);
        @(posedge sys_clk);
        #1;
        `CHK(port_rst_n, 3'b111, "all ports release")
        $display("end t_port_reset");
    endtask

    initial
    begin
        failures = 0;
        check_count = 0;
        nrst = 1'b0;
        ce = 1'b1;
        is_upstream = 1'b0;
        ds_port_sel = 3'b010;
        pin_load_we = 1'b0;
        pin_load_val = 8'h00;
        pf_base_lo = 12'h000;
        pf_lim_lo = 12'h000;
        io_base_lo = 4'h0;
        io_lim_lo = 4'h0;
        mem_valid = 1'b0;
        mem_addr = 64'h0;
        io_valid = 1'b0;
        io_addr = 32'h0;
        sec_poison = 1'b0;
        sec_err_valid = 1'b0;
        sec_err_type = 2'b00;
        repeat (6) @(posedge sys_clk);
        nrst <= 1'b1;
        t_reset_values();
        t_reg_access();
        t_pin_load();
        t_prefetch();
        t_vga();
        t_isa_window();
        t_events();
        t_clock_enable();
        t_port_reset();
        final_report();
    end
endmodule
`default_nettype wire
